// ---- sbseq_top.sv ----
// Power-on and brownout sequencer of a closed-loop fluxgate current sensor.
// Assumes supply comparator outputs and the degauss pin are asynchronous,
// and search and degauss engines answer with done levels on i_clk.
`timescale 1ns/1ps
`include "sbseq_consts.svh"
module sbseq_top #(
  parameter int SETTLE_CYC = `SBSEQ_SETTLE_CYC,
  parameter int LOOP_EN_CYC = `SBSEQ_LOOP_EN_CYC,
  parameter int BROWNOUT_CYC = `SBSEQ_BROWNOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_supply_above_hi,
  input wire logic i_supply_above_lo,
  input wire logic i_core_degauss_request,
  input wire logic i_sensor_saturated,
  input wire logic i_search_done,
  input wire logic i_degauss_done,
  input wire logic i_loop_coil_pos,
  input wire logic i_loop_coil_neg,
  input wire logic i_loop_error,
  output logic o_sensor_enable,
  output logic o_search_start,
  output logic o_degauss_start,
  output logic o_loop_enable,
  output logic o_coil_drive_pos,
  output logic o_coil_drive_neg,
  output logic o_fault_flag_n_out,
  output logic o_fault_flag_n_oe,
  output logic o_por
);
  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic above_hi;
  logic above_lo;
  logic degauss_req;

  sbseq_sync #(.RST_VAL(1'b0)) u_sync_hi (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_supply_above_hi),
    .o_sync(above_hi)
  );
  sbseq_sync #(.RST_VAL(1'b0)) u_sync_lo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_supply_above_lo),
    .o_sync(above_lo)
  );
  sbseq_sync #(.RST_VAL(1'b0)) u_sync_dg (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_core_degauss_request),
    .o_sync(degauss_req)
  );

  // ****************************************************************
  // Brownout detection
  // ****************************************************************
  logic por;

  sbseq_brownout #(.BROWNOUT_CYC(BROWNOUT_CYC)) u_brownout (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_above_hi(above_hi),
    .i_above_lo(above_lo),
    .o_por(por)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  sbseq_pkg::sbseq_state_t state;
  sbseq_pkg::sbseq_state_t next_state;
  logic [`SBSEQ_CNT_W-1:0] since_on;
  logic [`SBSEQ_CNT_W-1:0] next_since_on;
  logic degauss_seen;
  logic next_degauss_seen;
  logic settle_done;
  logic loop_time;
  logic in_startup;
  logic degauss_wanted;

  // One timer from power-on detection serves both settle and loop times
  assign settle_done = (since_on >= SETTLE_CYC[`SBSEQ_CNT_W-1:0]);
  assign loop_time = (since_on >= LOOP_EN_CYC[`SBSEQ_CNT_W-1:0]);
  assign next_since_on = (state == sbseq_pkg::SBSEQ_RESET) ? '0 :
    (loop_time ? since_on : since_on + 1'b1);
  // Request is latched so a short high level anywhere in start-up counts
  assign next_degauss_seen = (state == sbseq_pkg::SBSEQ_RESET) ? 1'b0 :
    (degauss_seen || (in_startup && degauss_req));
  assign in_startup = (state != sbseq_pkg::SBSEQ_RESET) && (state != sbseq_pkg::SBSEQ_RUN);
  // A request seen now or earlier in start-up both divert to degauss
  assign degauss_wanted = degauss_seen || degauss_req;

  always_comb begin
    next_state = state;
    unique case (state)
      sbseq_pkg::SBSEQ_RESET: begin
        if (above_hi) begin
          next_state = sbseq_pkg::SBSEQ_SETTLE;
        end
      end
      sbseq_pkg::SBSEQ_SETTLE: begin
        if (settle_done) begin
          next_state = sbseq_pkg::SBSEQ_SENSOR_UP;
        end
      end
      sbseq_pkg::SBSEQ_SENSOR_UP: begin
        if (i_sensor_saturated) begin
          next_state = sbseq_pkg::SBSEQ_SEARCH;
        end else if (degauss_wanted) begin
          next_state = sbseq_pkg::SBSEQ_DEGAUSS;
        end else begin
          next_state = sbseq_pkg::SBSEQ_WAIT_LOOP;
        end
      end
      sbseq_pkg::SBSEQ_SEARCH: begin
        if (i_search_done) begin
          next_state = degauss_wanted ?
            sbseq_pkg::SBSEQ_DEGAUSS : sbseq_pkg::SBSEQ_WAIT_LOOP;
        end
      end
      sbseq_pkg::SBSEQ_DEGAUSS: begin
        if (i_degauss_done) begin
          next_state = sbseq_pkg::SBSEQ_RUN;
        end
      end
      sbseq_pkg::SBSEQ_WAIT_LOOP: begin
        if (degauss_wanted) begin
          next_state = sbseq_pkg::SBSEQ_DEGAUSS;
        end else if (loop_time) begin
          next_state = sbseq_pkg::SBSEQ_RUN;
        end
      end
      // Only a power-on reset or i_sys_rst leaves the running state
      sbseq_pkg::SBSEQ_RUN: begin
        next_state = sbseq_pkg::SBSEQ_RUN;
      end
      default: begin
        next_state = sbseq_pkg::SBSEQ_RESET;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= sbseq_pkg::SBSEQ_RESET;
      since_on <= '0;
      degauss_seen <= 1'b0;
    end else if (por) begin
      state <= sbseq_pkg::SBSEQ_RESET;
      since_on <= '0;
      degauss_seen <= 1'b0;
    end else begin
      state <= next_state;
      since_on <= next_since_on;
      degauss_seen <= next_degauss_seen;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic run;
  logic next_sensor_enable;
  logic next_fault_n;

  assign run = (state == sbseq_pkg::SBSEQ_RUN);
  assign next_sensor_enable = (state != sbseq_pkg::SBSEQ_RESET) &&
    (state != sbseq_pkg::SBSEQ_SETTLE);
  assign next_fault_n = run && !i_loop_error;
  // Start strobes are handshake outputs, high while the engine must run
  assign o_search_start = (state == sbseq_pkg::SBSEQ_SEARCH);
  assign o_degauss_start = (state == sbseq_pkg::SBSEQ_DEGAUSS);
  assign o_por = por;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sensor_enable <= 1'b0;
      o_loop_enable <= 1'b0;
      o_coil_drive_pos <= 1'b0;
      o_coil_drive_neg <= 1'b0;
      o_fault_flag_n_oe <= 1'b0;
    end else begin
      o_sensor_enable <= next_sensor_enable;
      o_loop_enable <= run;
      o_coil_drive_pos <= run && i_loop_coil_pos;
      o_coil_drive_neg <= run && i_loop_coil_neg;
      // Open drain: enable low means pulling the flag low
      o_fault_flag_n_oe <= next_fault_n;
    end
  end

  // Pin only ever drives low; release is by the enable
  assign o_fault_flag_n_out = 1'b0;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_settling;
    state == sbseq_pkg::SBSEQ_SETTLE;
  endsequence

  a_start_on_supply: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == sbseq_pkg::SBSEQ_RESET && above_hi && !por) |=> s_settling)
    else $error("Sequence did not start on supply good");

  a_settle_length: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_settling ##0 !settle_done) |=> (state != sbseq_pkg::SBSEQ_SENSOR_UP))
    else $error("Settle wait cut short");

  a_sensor_after_settle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_settling ##0 (settle_done && !por)) |=> ##1 o_sensor_enable)
    else $error("Sensor not enabled after settle");

  a_search_on_sat: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == sbseq_pkg::SBSEQ_SENSOR_UP && i_sensor_saturated && !por) |=> o_search_start)
    else $error("Search not launched on saturation");

  a_degauss_before_run: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state != sbseq_pkg::SBSEQ_RUN && $past(degauss_seen) && !por ##1 run)
      |-> $past(state) == sbseq_pkg::SBSEQ_DEGAUSS)
    else $error("Loop enabled without degauss cycle");

  a_run_timing: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(run) |-> (loop_time || $past(state) == sbseq_pkg::SBSEQ_DEGAUSS))
    else $error("Loop enabled early");

  a_coils_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!run ##1 !run) |-> (!o_coil_drive_pos && !o_coil_drive_neg && !o_fault_flag_n_oe))
    else $error("Coil driven or flag released during start-up");

  a_fault_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (run && !i_loop_error && !por) |=> o_fault_flag_n_oe)
    else $error("Fault flag not released");

  a_por_restart: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    por |=> (state == sbseq_pkg::SBSEQ_RESET && since_on == '0))
    else $error("Reset did not restart sequence");

  sequence s_searching;
    state == sbseq_pkg::SBSEQ_SEARCH;
  endsequence

  sequence s_degaussing;
    state == sbseq_pkg::SBSEQ_DEGAUSS;
  endsequence

  // Engines run as long as they need; start-up has no timeout of its own
  a_search_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_searching ##0 (!i_search_done && !por)) |=> o_search_start)
    else $error("Search left before it finished");

  a_degauss_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_degaussing ##0 (!i_degauss_done && !por)) |=> o_degauss_start)
    else $error("Degauss left before it finished");

  a_degauss_to_run: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_degaussing ##0 (i_degauss_done && !por)) |=> run ##1 o_loop_enable)
    else $error("Loop not enabled at degauss end");

  a_loop_at_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == sbseq_pkg::SBSEQ_WAIT_LOOP && loop_time && !degauss_wanted && !por) |=> run)
    else $error("Loop not enabled at its time");

  // The lower comparator must not wait for the brownout filter
  a_deep_drop_reset: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !above_lo |=> (state == sbseq_pkg::SBSEQ_RESET) ##1 !o_loop_enable)
    else $error("Deep supply drop did not stop the loop");

  a_sensor_off_early: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == sbseq_pkg::SBSEQ_RESET || state == sbseq_pkg::SBSEQ_SETTLE) |=> !o_sensor_enable)
    else $error("Sensor enabled before settle ended");

  // A stale count would let a restarted sequence cut its settle wait short
  a_timer_cleared: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == sbseq_pkg::SBSEQ_RESET) |-> (since_on == '0))
    else $error("Interval timer not cleared in reset");

  a_flag_on_error: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_loop_error |=> !o_fault_flag_n_oe)
    else $error("Fault flag released during loop error");

  // Coils follow the loop one cycle late once running
  a_coil_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    run |=> (o_coil_drive_pos == $past(i_loop_coil_pos) &&
      o_coil_drive_neg == $past(i_loop_coil_neg)))
    else $error("Coil drive does not follow the loop");
endmodule

// ---- sbseq_consts.svh ----
// Timing constants for the sensor start-up and brownout sequencer.
// Assumes a 200 MHz core clock; counts derive from times in ns.
`ifndef SBSEQ_CONSTS_SVH
`define SBSEQ_CONSTS_SVH

`define SBSEQ_CLK_PERIOD_NS 5
`define SBSEQ_SETTLE_NS 26000
`define SBSEQ_LOOP_EN_NS 80000
`define SBSEQ_BROWNOUT_NS 20000
// Least times round up to whole cycles
`define SBSEQ_SETTLE_CYC ((`SBSEQ_SETTLE_NS + `SBSEQ_CLK_PERIOD_NS - 1) / `SBSEQ_CLK_PERIOD_NS)
`define SBSEQ_LOOP_EN_CYC ((`SBSEQ_LOOP_EN_NS + `SBSEQ_CLK_PERIOD_NS - 1) / `SBSEQ_CLK_PERIOD_NS)
`define SBSEQ_BROWNOUT_CYC ((`SBSEQ_BROWNOUT_NS + `SBSEQ_CLK_PERIOD_NS - 1) / `SBSEQ_CLK_PERIOD_NS)
`define SBSEQ_CNT_W 15

`endif

// ---- sbseq_pkg.sv ----
// Types shared by the sequencer modules.
// Assumes nothing of its surroundings.
package sbseq_pkg;
  typedef enum logic [2:0] {
    SBSEQ_RESET,
    SBSEQ_SETTLE,
    SBSEQ_SENSOR_UP,
    SBSEQ_SEARCH,
    SBSEQ_DEGAUSS,
    SBSEQ_WAIT_LOOP,
    SBSEQ_RUN
  } sbseq_state_t;
endpackage

// ---- sbseq_sync.sv ----
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to i_clk.
`timescale 1ns/1ps
module sbseq_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic stage1;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage1 <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

// ---- sbseq_brownout.sv ----
// Brownout filter: turns synchronised supply comparator levels into a
// power-on reset request. Assumes inputs are already synchronised.
`timescale 1ns/1ps
`include "sbseq_consts.svh"
module sbseq_brownout #(
  parameter int BROWNOUT_CYC = `SBSEQ_BROWNOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_above_hi,
  input wire logic i_above_lo,
  output logic o_por
);
  logic [`SBSEQ_CNT_W-1:0] low_cnt;
  logic [`SBSEQ_CNT_W-1:0] next_low_cnt;
  logic filt_expired;

  assign filt_expired = (low_cnt >= BROWNOUT_CYC[`SBSEQ_CNT_W-1:0]);
  assign next_low_cnt = i_above_hi ? '0 :
    (filt_expired ? low_cnt : low_cnt + 1'b1);
  // Deep drop bypasses the filter; a long shallow dip trips it
  assign o_por = !i_above_lo || (!i_above_hi && filt_expired);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= next_low_cnt;
    end
  end

  a_lo_immediate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_above_lo |-> o_por)
    else $error("Deep supply drop did not raise reset");

  a_short_dip_ignored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_above_lo && $rose(!i_above_hi)) |-> (!o_por)[*8])
    else $error("Short dip raised reset");
endmodule

// ---- sbseq_host_model.sv ----
// Host side of the open-drain fault flag: a pull-up resistor and a monitor.
// Assumes the device drives the flag only while its output enable is low.
`timescale 1ns/1ps
module sbseq_host_model (
  input wire logic i_fault_flag_n_out,
  input wire logic i_fault_flag_n_oe,
  output logic o_fault_level
);
  // Released line floats up to the pull-up level, never to the last value
  assign o_fault_level = (i_fault_flag_n_oe === 1'b0) ? i_fault_flag_n_out : 1'b1;
endmodule

// ---- tb.sv ----
// Self-checking bench for the start-up and brownout sequencer.
// Assumes short interval parameters; supply comparators driven as levels.
`timescale 1ns/1ps
module tb;
  localparam int SETTLE_CYC = 20;
  localparam int LOOP_EN_CYC = 60;
  localparam int BROWNOUT_CYC = 10;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_supply_above_hi = 1'b0;
  logic i_supply_above_lo = 1'b0;
  logic i_core_degauss_request = 1'b0;
  logic i_sensor_saturated = 1'b0;
  logic i_search_done = 1'b0;
  logic i_degauss_done = 1'b0;
  logic i_loop_coil_pos = 1'b1;
  logic i_loop_coil_neg = 1'b1;
  logic i_loop_error = 1'b0;
  logic o_sensor_enable, o_search_start, o_degauss_start, o_loop_enable;
  logic o_coil_drive_pos, o_coil_drive_neg, o_fault_flag_n_out, o_fault_flag_n_oe;
  logic o_por, fault_level;
  int n_errors = 0;
  int comparisons = 0;

  sbseq_top #(.SETTLE_CYC(SETTLE_CYC), .LOOP_EN_CYC(LOOP_EN_CYC),
    .BROWNOUT_CYC(BROWNOUT_CYC)) u_sbseq_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_supply_above_hi(i_supply_above_hi), .i_supply_above_lo(i_supply_above_lo),
    .i_core_degauss_request(i_core_degauss_request),
    .i_sensor_saturated(i_sensor_saturated), .i_search_done(i_search_done),
    .i_degauss_done(i_degauss_done), .i_loop_coil_pos(i_loop_coil_pos),
    .i_loop_coil_neg(i_loop_coil_neg), .i_loop_error(i_loop_error),
    .o_sensor_enable(o_sensor_enable), .o_search_start(o_search_start),
    .o_degauss_start(o_degauss_start), .o_loop_enable(o_loop_enable),
    .o_coil_drive_pos(o_coil_drive_pos), .o_coil_drive_neg(o_coil_drive_neg),
    .o_fault_flag_n_out(o_fault_flag_n_out), .o_fault_flag_n_oe(o_fault_flag_n_oe),
    .o_por(o_por));
  sbseq_host_model u_sbseq_host_model (.i_fault_flag_n_out(o_fault_flag_n_out),
    .i_fault_flag_n_oe(o_fault_flag_n_oe), .o_fault_level(fault_level));

  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic stop_test();
    $display("errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  function automatic logic out_sel(input int k);
    case (k)
      0: out_sel = o_sensor_enable;
      1: out_sel = o_loop_enable;
      2: out_sel = o_search_start;
      3: out_sel = o_degauss_start;
      default: out_sel = o_por;
    endcase
  endfunction

  // Counts cycles until the chosen output is high; idle outputs are checked meanwhile
  task automatic wait_out(input int k, inout int n);
    int lim;
    lim = n + 300;
    while (out_sel(k) !== 1'b1) begin
      if (o_loop_enable !== 1'b1) begin
        check(o_coil_drive_pos === 1'b0 && o_coil_drive_neg === 1'b0, "coil driven");
        check(fault_level === 1'b0, "fault flag released early");
      end
      if (n >= lim) begin
        check(1'b0, "wait limit reached");
        stop_test();
      end
      @(negedge i_clk);
      n++;
    end
  endtask

  task automatic power_cycle(input logic sat, input logic deg);
    i_supply_above_hi = 1'b0;
    i_supply_above_lo = 1'b0;
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
    i_sensor_saturated = sat;
    i_core_degauss_request = deg;
    repeat (2) @(negedge i_clk);
    i_supply_above_lo = 1'b1;
    i_supply_above_hi = 1'b1;
  endtask

  // Plain start-up from the moment the supply is seen above the upper level
  task automatic seq_check();
    int n;
    n = 0;
    wait_out(0, n);
    check(n >= SETTLE_CYC && n <= SETTLE_CYC + 6, "sensor enable time");
    wait_out(1, n);
    check(n >= LOOP_EN_CYC && n <= LOOP_EN_CYC + 6, "loop enable time");
    @(negedge i_clk);
    check(fault_level === 1'b1, "fault flag not released");
    i_loop_coil_neg = 1'b0;
    repeat (2) @(negedge i_clk);
    check(o_coil_drive_pos === 1'b1 && o_coil_drive_neg === 1'b0, "coil follow");
    i_loop_coil_pos = 1'b0;
    i_loop_coil_neg = 1'b1;
    repeat (2) @(negedge i_clk);
    check(o_coil_drive_pos === 1'b0 && o_coil_drive_neg === 1'b1, "coil swap");
    i_loop_coil_pos = 1'b1;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_error_flag();
    i_loop_error = 1'b1;
    repeat (3) @(negedge i_clk);
    check(fault_level === 1'b0, "flag not asserted on loop error");
    i_loop_error = 1'b0;
    repeat (3) @(negedge i_clk);
    check(fault_level === 1'b1, "flag kept after error cleared");
  endtask

  task automatic t_brownout();
    i_supply_above_hi = 1'b0;
    repeat (BROWNOUT_CYC / 2) @(negedge i_clk);
    i_supply_above_hi = 1'b1;
    repeat (BROWNOUT_CYC) @(negedge i_clk);
    check(o_loop_enable === 1'b1 && o_por === 1'b0, "short dip not ignored");
    i_supply_above_hi = 1'b0;
    repeat (BROWNOUT_CYC + 8) @(negedge i_clk);
    check(o_por === 1'b1 && o_loop_enable === 1'b0, "long dip gave no reset");
    check(o_sensor_enable === 1'b0 && fault_level === 1'b0, "outputs after reset");
    i_loop_coil_neg = 1'b1;
    i_supply_above_hi = 1'b1;
    seq_check();
  endtask

  // Supply falls through both levels; reset must come long before the filter ends
  task automatic t_low_level();
    int n;
    n = 0;
    i_supply_above_lo = 1'b0;
    i_supply_above_hi = 1'b0;
    wait_out(4, n);
    check(n <= 4, "low level reset delayed");
    repeat (4) @(negedge i_clk);
    check(o_loop_enable === 1'b0 && o_sensor_enable === 1'b0, "outputs after deep drop");
    check(fault_level === 1'b0, "flag released after deep drop");
    i_supply_above_lo = 1'b1;
    i_supply_above_hi = 1'b1;
    i_loop_coil_neg = 1'b1;
    seq_check();
  endtask

  task automatic t_search();
    int n;
    n = 0;
    power_cycle(1'b1, 1'b0);
    wait_out(2, n);
    check(n >= SETTLE_CYC && n <= SETTLE_CYC + 8, "search not launched");
    repeat (3) @(negedge i_clk);
    n += 3;
    check(o_search_start === 1'b1 && o_loop_enable === 1'b0, "search not awaited");
    i_search_done = 1'b1;
    i_sensor_saturated = 1'b0;
    @(negedge i_clk);
    i_search_done = 1'b0;
    wait_out(1, n);
    check(n >= LOOP_EN_CYC && n <= LOOP_EN_CYC + 6, "loop after search");
  endtask

  task automatic t_degauss();
    int n;
    n = 0;
    power_cycle(1'b0, 1'b1);
    wait_out(3, n);
    check(n >= SETTLE_CYC && o_loop_enable === 1'b0, "degauss start");
    repeat (3) @(negedge i_clk);
    n += 3;
    check(o_degauss_start === 1'b1 && o_loop_enable === 1'b0, "degauss not awaited");
    i_degauss_done = 1'b1;
    i_core_degauss_request = 1'b0;
    @(negedge i_clk);
    i_degauss_done = 1'b0;
    wait_out(1, n);
    check(n < LOOP_EN_CYC && n <= SETTLE_CYC + 14, "loop not enabled at degauss end");
  endtask

  initial begin
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    i_supply_above_lo = 1'b1;
    i_supply_above_hi = 1'b1;
    seq_check();
    t_error_flag();
    t_brownout();
    t_low_level();
    t_search();
    t_degauss();
    stop_test();
  end
endmodule
